/* File: core/cfgldr_top.sv */
// configuration loader: chain hand-off, error line, flash reads, remote update status
// Operation
// - flash configuration clock never runs faster than 40 MHz.
// - dense flash: drive upper address bit and flash select during reads.
// - after own configuration completes, drive chain enable output low.
// - start accepting data within one clock after chip enable asserts; the loader reaches its load state on the third clock after the pin.
// - shared lines; all devices enter user mode together via completion line.
// - any error halts the whole chain; restart needs full reconfiguration.
// - on a detected error pull the shared open-drain error line low.
// - config reset assertion and watchdog time-out both trigger reconfiguration.
// - status word top two bits show the master state.
// - factory: zero reserved field, 24-bit boot address below.
// - application word one: watchdog enable bit and 29-bit time-out.
// - application word two: zero padding above 24-bit boot address.
// - keep two earlier application state words for debug.
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
module cfgldr_top (
    // system
    input wire logic clk_sys,
    input wire logic reset_n,
    // register bus
    input wire logic [cfgldr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // configuration link
    input wire logic config_reset_n,
    input wire logic chip_enable_in_n,
    input wire logic config_serial_clock,
    input wire logic config_data,
    input wire logic config_error_line_n_in,
    output logic config_error_line_n_out,
    output logic config_error_line_n_oe,
    input wire logic config_complete_in,
    output logic config_complete_out,
    output logic config_complete_oe,
    output logic chain_enable_out_n,
    // parallel flash
    output logic flash_clk,
    output logic flash_select_n,
    output logic [cfgldr_pkg::FLASH_A_W-1:0] flash_addr,
    input wire logic [cfgldr_pkg::WORD_W-1:0] flash_data,
    // status
    output logic user_mode,
    output logic irq
);
    import cfgldr_pkg::*;

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // synchronised pins
    logic s_cfg_rst_n, s_ce_n, s_sclk, s_data, s_err_n, s_complete;
    logic [WORD_W-1:0] s_fdata;

    cfgldr_sync #(.WIDTH(6 + WORD_W)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din({config_reset_n, chip_enable_in_n, config_serial_clock, config_data,
              config_error_line_n_in, config_complete_in, flash_data}),
        .dout({s_cfg_rst_n, s_ce_n, s_sclk, s_data, s_err_n, s_complete, s_fdata})
    );

    cfgldr_state_t state;
    logic sclk_q, cfg_rst_q, was_done, was_err;
    logic par_mode, dense_flash, wd_enable, app_req, wd_kick, bus_ack;
    logic [BOOT_W-1:0] app_addr, boot_addr;
    logic [WORD_W-1:0] image_len, word_cnt, shift, xor_acc, word_in;
    logic [3:0] bit_cnt, pcnt;
    logic [WD_W-1:0] wd_timeout, wd_cnt;
    logic [IRQ_W-1:0] irq_status, irq_mask, irq_evt, irq_clr;
    logic [1:0] master_state;
    logic [31:0] cur_info1, cur_info2, prev1, prev2, rd_mux, wr_val, w1c_val;

    // edge finding on the sampled link clock and reset line
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sclk_q <= 1'b0;
            cfg_rst_q <= 1'b0;
        end else begin
            sclk_q <= s_sclk;
            cfg_rst_q <= s_cfg_rst_n;
        end
    end

    wire sclk_rise = s_sclk & ~sclk_q;
    wire cfg_rst_fall = cfg_rst_q & ~s_cfg_rst_n;
    wire wd_run = user_mode & wd_enable & (master_state == MS_APP);
    wire wd_expire = wd_run & (wd_cnt == wd_timeout);
    wire reconfig = cfg_rst_fall | wd_expire | app_req;
    wire loading = (state == ST_LOAD);
    wire take_ser = loading & ~par_mode & sclk_rise & (bit_cnt == 4'hF);
    wire take_par = loading & par_mode & (pcnt == PAR_WORD_CYC - 4'h1);
    wire word_take = take_ser | take_par;
    wire last_word = word_cnt == image_len - 16'h0001;
    wire peer_err = ~s_err_n & ~config_error_line_n_oe;

    assign word_in = par_mode ? s_fdata : {s_data, shift[WORD_W-1:1]};

    // register bus: one wait state on every access
    wire bus_req = avs_read | avs_write;
    wire wr_go = avs_write & bus_ack;
    assign avs_waitrequest = bus_req & ~bus_ack;
    assign wr_val = be_merge(rd_mux, avs_writedata, avs_byteenable);
    assign w1c_val = be_merge(32'h0, avs_writedata, avs_byteenable);

    always_comb begin
        case (avs_address)
            REG_CTRL: begin
                rd_mux = {25'h0, state, user_mode, 1'b0, dense_flash, par_mode};
            end
            REG_APP_ADDR: rd_mux = {8'h00, app_addr};
            REG_IMAGE_LEN: rd_mux = {16'h0000, image_len};
            REG_WD_CFG: rd_mux = {2'b00, wd_enable, wd_timeout};
            REG_CUR_INFO1: rd_mux = cur_info1;
            REG_CUR_INFO2: rd_mux = cur_info2;
            REG_PREV1: rd_mux = prev1;
            REG_PREV2: rd_mux = prev2;
            REG_IRQ_STATUS: rd_mux = {29'h0, irq_status};
            REG_IRQ_MASK: rd_mux = {29'h0, irq_mask};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus_ack <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
            if (bus_req & ~bus_ack) begin
                avs_readdata <= avs_read ? rd_mux : 32'h0;
            end
        end
    end

    // software settings
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            par_mode <= 1'b0;
            dense_flash <= 1'b0;
            app_addr <= APP_ADDR_RST;
            image_len <= IMAGE_LEN_RST;
            wd_enable <= 1'b0;
            wd_timeout <= WD_TIMEOUT_RST;
            irq_mask <= IRQ_MASK_RST;
        end else if (wr_go) begin
            case (avs_address)
                REG_CTRL: begin
                    par_mode <= wr_val[CTRL_PAR_BIT];
                    dense_flash <= wr_val[CTRL_DENSE_BIT];
                end
                REG_APP_ADDR: app_addr <= wr_val[BOOT_W-1:0];
                REG_IMAGE_LEN: image_len <= wr_val[WORD_W-1:0];
                REG_WD_CFG: begin
                    wd_enable <= wr_val[ST_WDEN_BIT];
                    wd_timeout <= wr_val[WD_W-1:0];
                end
                REG_IRQ_MASK: irq_mask <= wr_val[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // command pulses
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            app_req <= 1'b0;
            wd_kick <= 1'b0;
        end else begin
            app_req <= wr_go & (avs_address == REG_CTRL) & wr_val[CTRL_APP_BIT];
            wd_kick <= wr_go & (avs_address == REG_WD_KICK);
        end
    end

    // user watchdog
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wd_cnt <= '0;
        end else if (!wd_run || wd_kick || wd_expire) begin
            wd_cnt <= '0;
        end else begin
            wd_cnt <= wd_cnt + 29'h1;
        end
    end

    // remote update master state and boot address
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            master_state <= MS_FACTORY;
            boot_addr <= FACTORY_ADDR;
        end else if (cfg_rst_fall || wd_expire) begin
            master_state <= MS_FACTORY;
            boot_addr <= FACTORY_ADDR;
        end else if (app_req) begin
            master_state <= MS_APP;
            boot_addr <= app_addr;
        end
    end

    // history of the application configurations left behind
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prev1 <= 32'h0;
            prev2 <= 32'h0;
        end else if (reconfig && master_state == MS_APP) begin
            prev1 <= cur_info1;
            prev2 <= prev1;
        end
    end

    cfgldr_status_word u_status (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .master_state(master_state),
        .boot_addr(boot_addr),
        .wd_enable(wd_enable),
        .wd_timeout(wd_timeout),
        .info1(cur_info1),
        .info2(cur_info2)
    );

    // load sequence; a peer pulling the error line resets this device too
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= ST_IDLE;
        end else if (reconfig || !s_cfg_rst_n || peer_err) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: state <= ST_WAIT_CE;
                ST_WAIT_CE: if (!s_ce_n) state <= ST_LOAD;
                ST_LOAD: begin
                    if (word_take && last_word) begin
                        state <= (word_in == xor_acc) ? ST_DONE : ST_ERROR;
                    end
                end
                ST_DONE: state <= ST_DONE;
                ST_ERROR: state <= ST_ERROR;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // word assembly and check value; counters rest outside a load
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !loading) begin
            shift <= '0;
            bit_cnt <= 4'h0;
            word_cnt <= '0;
            xor_acc <= '0;
            pcnt <= 4'h0;
        end else begin
            if (!par_mode && sclk_rise) begin
                shift <= word_in;
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (par_mode) begin
                pcnt <= take_par ? 4'h0 : pcnt + 4'h1;
            end
            if (word_take) begin
                word_cnt <= word_cnt + 16'h0001;
                xor_acc <= xor_acc ^ word_in;
            end
        end
    end

    // flash side; data waits out the synchroniser before it is taken
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            flash_clk <= 1'b0;
            flash_select_n <= 1'b1;
            flash_addr <= '0;
        end else begin
            flash_clk <= loading & par_mode & (pcnt < FLASH_HALF_CYC);
            flash_select_n <= ~(loading & par_mode);
            if (dense_flash) begin
                flash_addr <= {1'b0, boot_addr} + 25'(word_cnt);
            end else begin
                flash_addr <= {1'b0, boot_addr[BOOT_W-1:0] + 24'(word_cnt)};
            end
        end
    end

    // shared pins
    assign config_error_line_n_out = 1'b0;
    assign config_complete_out = 1'b0;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            chain_enable_out_n <= 1'b1;
            config_complete_oe <= 1'b1;
            config_error_line_n_oe <= 1'b0;
            user_mode <= 1'b0;
        end else begin
            chain_enable_out_n <= state != ST_DONE;
            config_complete_oe <= state != ST_DONE;
            config_error_line_n_oe <= state == ST_ERROR;
            user_mode <= (state == ST_DONE) & s_complete;
        end
    end

    // interrupts: set wins over a write-one clear
    assign irq_evt = {reconfig, (state == ST_ERROR) & ~was_err, (state == ST_DONE) & ~was_done};
    assign irq_clr = (wr_go && avs_address == REG_IRQ_STATUS) ? w1c_val[IRQ_W-1:0] : '0;
    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            irq_status <= '0;
            was_done <= 1'b0;
            was_err <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_evt;
            was_done <= state == ST_DONE;
            was_err <= state == ST_ERROR;
        end
    end

    property p_flash_rate;
        @(posedge clk_sys) disable iff (!reset_n)
        $fell(flash_clk) |-> !flash_clk [*2];
    endproperty
    a_flash_rate: assert property (p_flash_rate)
        else $error("flash clock low phase too short");

    property p_dense_addr;
        @(posedge clk_sys) disable iff (!reset_n)
        (!dense_flash && !flash_select_n) |-> !flash_addr[FLASH_A_W-1];
    endproperty
    a_dense_addr: assert property (p_dense_addr)
        else $error("upper flash address bit driven without dense flash");

    property p_chain_out;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_DONE) |=> !chain_enable_out_n ##1 (chain_enable_out_n == $past(state != ST_DONE));
    endproperty
    a_chain_out: assert property (p_chain_out)
        else $error("chain enable output does not follow completion");

    property p_ce_start;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_WAIT_CE && !s_ce_n && s_cfg_rst_n && !peer_err && !reconfig) |=> loading;
    endproperty
    a_ce_start: assert property (p_ce_start)
        else $error("load did not start after chip enable");

    property p_user_mode;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(user_mode) |-> $past(s_complete) && !config_complete_oe;
    endproperty
    a_user_mode: assert property (p_user_mode)
        else $error("user mode entered while completion line low");

    property p_peer_halt;
        @(posedge clk_sys) disable iff (!reset_n)
        peer_err |=> state == ST_IDLE ##1 !user_mode;
    endproperty
    a_peer_halt: assert property (p_peer_halt)
        else $error("chain error did not halt this device");

    property p_err_drive;
        @(posedge clk_sys) disable iff (!reset_n)
        (state == ST_LOAD && word_take && last_word && word_in != xor_acc && s_cfg_rst_n
            && !peer_err && !reconfig) |=> ##1 config_error_line_n_oe;
    endproperty
    a_err_drive: assert property (p_err_drive)
        else $error("error line not pulled after bad image");

    property p_reconfig;
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg_rst_fall || wd_expire) |=> master_state == MS_FACTORY && state == ST_IDLE;
    endproperty
    a_reconfig: assert property (p_reconfig)
        else $error("reconfiguration event not handled");

    property p_history;
        @(posedge clk_sys) disable iff (!reset_n)
        (reconfig && master_state == MS_APP) |=> prev1 == $past(cur_info1) && prev2 == $past(prev1);
    endproperty
    a_history: assert property (p_history)
        else $error("history registers not shifted");

    c_done: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(user_mode));
    c_error: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(config_error_line_n_oe));
    c_app: cover property (@(posedge clk_sys) disable iff (!reset_n)
        master_state == MS_APP && user_mode);
    c_wd: cover property (@(posedge clk_sys) disable iff (!reset_n) wd_expire);
endmodule : cfgldr_top

/* File: shared/cfgldr_pkg.sv */
// constants, register map and state codes of the configuration loader
package cfgldr_pkg;
    // clock and flash rate
    localparam int CLK_HZ = 40_000_000;
    localparam int FLASH_MAX_HZ = 40_000_000;
    localparam int FLASH_HALF_INT = (CLK_HZ + 2 * FLASH_MAX_HZ - 1) / (2 * FLASH_MAX_HZ);
    localparam logic [3:0] FLASH_HALF_CYC = 4'((FLASH_HALF_INT < 1) ? 1 : FLASH_HALF_INT);
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] PAR_WORD_CYC = 4'(2 * FLASH_HALF_CYC + 4'(SYNC_STAGES));

    // widths
    localparam int ADDR_W = 8;
    localparam int WORD_W = 16;
    localparam int BOOT_W = 24;
    localparam int FLASH_A_W = 25;
    localparam int WD_W = 29;
    localparam int IRQ_W = 3;

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_APP_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IMAGE_LEN = 8'h08;
    localparam logic [ADDR_W-1:0] REG_WD_CFG = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_WD_KICK = 8'h10;
    localparam logic [ADDR_W-1:0] REG_CUR_INFO1 = 8'h14;
    localparam logic [ADDR_W-1:0] REG_CUR_INFO2 = 8'h18;
    localparam logic [ADDR_W-1:0] REG_PREV1 = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_PREV2 = 8'h20;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h24;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h28;

    // field positions
    localparam int CTRL_PAR_BIT = 0;
    localparam int CTRL_DENSE_BIT = 1;
    localparam int CTRL_APP_BIT = 2;
    localparam int CTRL_USER_BIT = 3;
    localparam int CTRL_STATE_LSB = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int IRQ_RECFG_BIT = 2;
    localparam int ST_WDEN_BIT = 29;

    // master state codes
    localparam logic [1:0] MS_FACTORY = 2'h1;
    localparam logic [1:0] MS_APP = 2'h2;

    // reset values
    localparam logic [BOOT_W-1:0] FACTORY_ADDR = 24'h000000;
    localparam logic [BOOT_W-1:0] APP_ADDR_RST = 24'h000000;
    localparam logic [WORD_W-1:0] IMAGE_LEN_RST = 16'h0004;
    localparam logic [WD_W-1:0] WD_TIMEOUT_RST = 29'h1FFFFFFF;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_CE = 3'b001,
        ST_LOAD = 3'b010,
        ST_DONE = 3'b011,
        ST_ERROR = 3'b100
    } cfgldr_state_t;
endpackage : cfgldr_pkg

/* File: core/cfgldr_sync.sv */
// two-stage synchroniser for pins from outside the clock domain
module cfgldr_sync #(
    parameter int WIDTH = 1
) (
    // system
    input wire logic clk_sys,
    input wire logic reset_n,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : cfgldr_sync

/* File: core/cfgldr_status_word.sv */
// assembles the two current-state words of the remote update logic
module cfgldr_status_word (
    // system
    input wire logic clk_sys,
    input wire logic reset_n,
    // state
    input wire logic [1:0] master_state,
    input wire logic [cfgldr_pkg::BOOT_W-1:0] boot_addr,
    input wire logic wd_enable,
    input wire logic [cfgldr_pkg::WD_W-1:0] wd_timeout,
    // words
    output logic [31:0] info1,
    output logic [31:0] info2
);
    import cfgldr_pkg::*;

    always_comb begin
        if (master_state == MS_APP) begin
            info1 = {master_state, wd_enable, wd_timeout};
        end else begin
            info1 = {master_state, 6'h00, boot_addr};
        end
        info2 = {master_state, 6'h00, boot_addr};
    end

    property p_state_field;
        @(posedge clk_sys) disable iff (!reset_n)
        $changed(master_state) |-> info1[31:30] == master_state && info2[31:30] == master_state;
    endproperty
    a_state_field: assert property (p_state_field)
        else $error("state field differs from master state");

    property p_factory_word;
        @(posedge clk_sys) disable iff (!reset_n)
        master_state == MS_FACTORY |-> info1[29:24] == 6'h00 && info1[23:0] == boot_addr;
    endproperty
    a_factory_word: assert property (p_factory_word)
        else $error("factory word wrong");

    property p_app_word;
        @(posedge clk_sys) disable iff (!reset_n)
        master_state == MS_APP |-> info1[29] == wd_enable && info1[28:0] == wd_timeout
            && info2[29:24] == 6'h00 && info2[23:0] == boot_addr;
    endproperty
    a_app_word: assert property (p_app_word)
        else $error("application words wrong");
endmodule : cfgldr_status_word

/* File: testbench/cfgldr_host_model.sv */
// serial configuration host and parallel flash on the far side of the loader
module cfgldr_host_model (
    // serial link
    output logic config_serial_clock,
    output logic config_data,
    // flash
    input wire logic flash_select_n,
    input wire logic flash_clk,
    input wire logic [24:0] flash_addr,
    output logic [15:0] flash_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        config_serial_clock = 1'b0;
        config_data = 1'b0;
    end
    // a deselected flash must not keep showing a stale word
    assign flash_data = flash_select_n ? {16{flash_clk}} ^ 16'hA5A5 : flash_addr[15:0];
    // shared clock and data lines, lsb first; clock parked low between frames
    task automatic send(input logic [15:0] w);
        for (int i = 0; i < 16; i++) begin
            config_data = w[i];
            #100 config_serial_clock = 1'b1;
            #100 config_serial_clock = 1'b0;
        end
        config_data = ~w[15];
    endtask : send
endmodule : cfgldr_host_model

/* File: testbench/test_config_chain_and_upgrade_status.sv */
// self-checking bench of the configuration loader
module test_config_chain_and_upgrade_status;
    timeunit 1ns;
    timeprecision 100ps;
    import cfgldr_pkg::*;
    logic [23:0] app_a;
    logic clk_sys, reset_n, avs_read, avs_write, cfg_rst_n, ce_n, err_oe, cpl_oe;
    logic avs_waitrequest, chain_n, fclk, fsel_n, user_mode, irq, sclk, sdat;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [24:0] faddr;
    logic [15:0] fdata;
    logic [31:0] exp_q[$];
    string nm_q[$];
    int num_errors = 0;
    int total_checks = 0;
    // pulled-up shared lines: only this device pulls them in the bench
    wire err_line = err_oe ? 1'b0 : 1'b1;
    wire cpl_line = cpl_oe ? 1'b0 : 1'b1;
    cfgldr_top cfgldr_top_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .config_reset_n(cfg_rst_n),
        .chip_enable_in_n(ce_n), .config_serial_clock(sclk), .config_data(sdat),
        .config_error_line_n_in(err_line), .config_error_line_n_out(),
        .config_error_line_n_oe(err_oe), .config_complete_in(cpl_line),
        .config_complete_out(), .config_complete_oe(cpl_oe), .chain_enable_out_n(chain_n),
        .flash_clk(fclk), .flash_select_n(fsel_n), .flash_addr(faddr), .flash_data(fdata),
        .user_mode(user_mode), .irq(irq));
    cfgldr_host_model cfgldr_host_model_inst (.config_serial_clock(sclk),
        .config_data(sdat), .flash_select_n(fsel_n), .flash_clk(fclk),
        .flash_addr(faddr), .flash_data(fdata));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // read results are judged where they appear, against the oldest note
    always @(negedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            chk(nm_q.pop_front(), exp_q.pop_front(), avs_readdata);
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(negedge clk_sys); while (avs_waitrequest !== 1'b0);
        @(posedge clk_sys);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic load(input logic bad);
        logic [15:0] w;
        logic [15:0] x;
        x = 16'h0000;
        repeat (10) @(posedge clk_sys);
        for (int i = 0; i < 3; i++) begin
            w = 16'($urandom);
            x ^= w;
            cfgldr_host_model_inst.send(w);
        end
        cfgldr_host_model_inst.send(x ^ {15'h0, bad});
        for (int i = 0; i < 50 && chain_n !== 1'b0 && err_oe !== 1'b1; i++) @(negedge clk_sys);
        repeat (3) @(negedge clk_sys);
    endtask : load
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    initial begin
        #300us;
        num_errors++;
        finish_test;
    end
    initial begin
        void'($urandom(32'hac099e4d));
        {reset_n, avs_read, avs_write, ce_n} = 4'b0000;
        ce_n = 1'b1;
        cfg_rst_n = 1'b1;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        bus(1'b1, REG_CUR_INFO1, 32'hFFFFFFFF);
        rd(REG_CUR_INFO1, {MS_FACTORY, 6'h00, FACTORY_ADDR}, "info1");
        rd(REG_CUR_INFO2, {MS_FACTORY, 6'h00, FACTORY_ADDR}, "info2");
        rd(REG_IMAGE_LEN, 32'h4, "image_len");
        rd(REG_WD_CFG, {3'h0, WD_TIMEOUT_RST}, "wd_cfg");
        rd(REG_IRQ_MASK, 32'h0, "irq_mask");
        rd(8'hFC, 32'h0, "unmapped");
        bus(1'b1, REG_IRQ_MASK, 32'h1);
        ce_n <= 1'b0;
        @(negedge clk_sys);
        chk("chain_out_idle", 32'h1, chain_n);
        load(1'b0);
        chk("chain_out", 32'h0, chain_n);
        chk("user_mode", 32'h1, user_mode);
        chk("irq_done", 32'h1, irq);
        rd(REG_CTRL, 32'h38, "ctrl");
        rd(REG_IRQ_STATUS, 32'h1, "irq_status");
        bus(1'b1, REG_IRQ_STATUS, 32'h1);
        @(negedge clk_sys);
        chk("irq_cleared", 32'h0, irq);
        @(posedge clk_sys);
        cfg_rst_n <= 1'b0;
        repeat (5) @(negedge clk_sys);
        chk("chain_out_reset", 32'h1, chain_n);
        chk("user_mode_reset", 32'h0, user_mode);
        @(posedge clk_sys);
        cfg_rst_n <= 1'b1;
        load(1'b1);
        chk("error_pull", 32'h1, err_oe);
        chk("chain_out_err", 32'h1, chain_n);
        rd(REG_IRQ_STATUS, 32'h6, "irq_status_err");
        bus(1'b1, REG_IRQ_MASK, 32'h2);
        @(negedge clk_sys);
        chk("irq_err", 32'h1, irq);
        // application image, then back to factory with a parallel flash load
        app_a = 24'($urandom);
        bus(1'b1, REG_APP_ADDR, {8'h00, app_a});
        bus(1'b1, REG_CTRL, 32'h4);
        rd(REG_CUR_INFO1, {MS_APP, 1'b0, WD_TIMEOUT_RST}, "app_info1");
        rd(REG_CUR_INFO2, {MS_APP, 6'h00, app_a}, "app_info2");
        bus(1'b1, REG_CTRL, 32'h1);
        @(posedge clk_sys);
        cfg_rst_n <= 1'b0;
        repeat (5) @(negedge clk_sys);
        rd(REG_PREV1, {MS_APP, 1'b0, WD_TIMEOUT_RST}, "prev1");
        rd(REG_CUR_INFO1, {MS_FACTORY, 6'h00, FACTORY_ADDR}, "info1_back");
        @(posedge clk_sys);
        cfg_rst_n <= 1'b1;
        for (int i = 0; i < 200 && chain_n !== 1'b0; i++) @(negedge clk_sys);
        chk("par_chain_out", 32'h0, chain_n);
        repeat (3) @(negedge clk_sys);
        chk("par_select_off", 32'h1, fsel_n);
        chk("par_user_mode", 32'h1, user_mode);
        finish_test;
    end
endmodule : test_config_chain_and_upgrade_status
